// ==== les_ctrl.sv ====
`timescale 1ns/1ns
module les_ctrl
  import les_pkg::*;
#(
  parameter int ENGINES = NUM_ENG
) (
  // Clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        srst_in,
  // Chip enable pin
  input  wire logic                        chip_en_in,
  // Operating mode requests
  input  wire logic [ENGINES-1:0]          opm_wr_in,
  input  wire logic [2*ENGINES-1:0]        opm_data_in,
  // Execution mode requests
  input  wire logic [ENGINES-1:0]          exm_wr_in,
  input  wire logic [2*ENGINES-1:0]        exm_data_in,
  // Program counter writes
  input  wire logic [ENGINES-1:0]          pc_wr_in,
  input  wire logic [les_pkg::PC_W-1:0]    pc_data_in,
  // Program memory access
  input  wire les_pkg::les_mem_req_t       mem_req_in,
  output logic [les_pkg::WORD_W-1:0]       mem_rd_data_out,
  // PWM from engines
  input  wire logic [8*ENGINES-1:0]        pwm_live_in,
  output logic [8*ENGINES-1:0]             pwm_out,
  // General purpose pin
  input  wire les_pkg::les_pin_cfg_t       pin_cfg_in,
  input  wire logic                        pin_in,
  output logic                             pin_out,
  output logic                             pin_oe_out,
  output logic                             pin_level_out,
  // Status
  output logic [2*ENGINES-1:0]             opm_out,
  output logic [2*ENGINES-1:0]             engine_exec_mode_field_out,
  output logic [les_pkg::PC_W*ENGINES-1:0] pc_out,
  output logic                             load_active_out,
  output logic [ENGINES-1:0]               exec_out,
  output logic [les_pkg::WORD_W-1:0]       fetch_data_out
);
  logic [1:0] opm_r [ENGINES];
  logic [1:0] exm_r [ENGINES];
  logic [ENGINES-1:0] exm_clr;
  logic [ENGINES-1:0] exec_w;
  logic [PC_W-1:0]    pc_w [ENGINES];
  logic               any_load;
  logic               en_s1_r;
  logic               en_s2_r;
  logic               pin_s1_r;
  logic               pin_s2_r;
  logic [MEM_AW-1:0]  fetch_addr;
  logic [WORD_W-1:0]  rd_data;
  logic [WORD_W-1:0]  fetch_data;

  // Is a mode change from cur to req allowed
  function automatic logic opm_legal(input logic [1:0] cur,
                                     input logic [1:0] req);
    opm_legal = (req != OPM_LOAD) || (cur == OPM_DISABLE) ||
                (cur == OPM_LOAD);
  endfunction

  function automatic logic pin_is_out(input logic [1:0] f);
    pin_is_out = (f == PINF_OUT_A) || (f == PINF_OUT_B);
  endfunction

  // Enable pin comes from outside; two-stage sync
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      en_s1_r  <= 1'b0;
      en_s2_r  <= 1'b0;
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end else begin
      en_s1_r  <= chip_en_in;
      en_s2_r  <= en_s1_r;
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  always_comb begin
    any_load = 1'b0;
    for (int i = 0; i < ENGINES; i++) begin
      if (opm_r[i] == OPM_LOAD) any_load = 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < ENGINES; g++) begin : g_eng
      // Host writes only count while the chip is enabled
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          opm_r[g] <= OPM_DISABLE;
        end else if (en_s2_r && opm_wr_in[g] &&
                     opm_legal(opm_r[g], opm_data_in[2*g +: 2])) begin
          opm_r[g] <= opm_data_in[2*g +: 2];
        end
      end

      // Host write wins over the hardware return to hold
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          exm_r[g] <= EXM_HOLD;
        end else if (en_s2_r && exm_wr_in[g]) begin
          exm_r[g] <= exm_data_in[2*g +: 2];
        end else if (exm_clr[g]) begin
          exm_r[g] <= EXM_HOLD;
        end
      end

      les_engine u_eng (
        .clk_in      (clk_in),
        .srst_in     (srst_in),
        .opm_in      (opm_r[g]),
        .gl_hold_in  (any_load),
        .exm_in      (exm_r[g]),
        .pc_wr_in    (en_s2_r && pc_wr_in[g]),
        .pc_data_in  (pc_data_in),
        .pc_out      (pc_w[g]),
        .exm_clr_out (exm_clr[g]),
        .exec_out    (exec_w[g])
      );

      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          opm_out[2*g +: 2]                    <= OPM_DISABLE;
          engine_exec_mode_field_out[2*g +: 2] <= EXM_HOLD;
          pc_out[PC_W*g +: PC_W]               <= PC_RST;
          pwm_out[8*g +: 8]                    <= 8'h00;
        end else begin
          opm_out[2*g +: 2]                    <= opm_r[g];
          engine_exec_mode_field_out[2*g +: 2] <= exm_r[g];
          pc_out[PC_W*g +: PC_W]               <= pc_w[g];
          if (!any_load) begin
            pwm_out[8*g +: 8] <= pwm_live_in[8*g +: 8];
          end
        end
      end
    end
  endgenerate

  // Fetch for the lowest executing engine; one shared read port
  always_comb begin
    fetch_addr = pc_w[0];
    for (int i = ENGINES - 1; i >= 0; i--) begin
      if (exec_w[i]) fetch_addr = pc_w[i];
    end
  end

  les_prog_mem u_mem (
    .clk_in         (clk_in),
    .req_in         (mem_req_in),
    .wr_allow_in    (any_load && en_s2_r),
    .rd_data_out    (rd_data),
    .fetch_addr_in  (fetch_addr),
    .fetch_data_out (fetch_data)
  );

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mem_rd_data_out <= 16'h0000;
      fetch_data_out  <= 16'h0000;
      load_active_out <= 1'b0;
      exec_out        <= '0;
    end else begin
      mem_rd_data_out <= rd_data;
      fetch_data_out  <= fetch_data;
      load_active_out <= any_load;
      exec_out        <= exec_w;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pin_out       <= 1'b0;
      pin_oe_out    <= 1'b0;
      pin_level_out <= 1'b0;
    end else begin
      pin_oe_out <= pin_is_out(pin_cfg_in.func);
      pin_out    <= pin_is_out(pin_cfg_in.func) && pin_cfg_in.level;
      if (!pin_is_out(pin_cfg_in.func)) begin
        pin_level_out <= pin_s2_r;
      end
    end
  end
endmodule

// ==== les_ctrl_props.sv ====
`timescale 1ns/1ns
module les_ctrl_props
  import les_pkg::*;
#(
  parameter int ENGINES = NUM_ENG
) (
  // Clock and reset
  input  wire logic                             clk_in,
  input  wire logic                             srst_in,
  // Watched ports
  input  wire logic [8*ENGINES-1:0]             pwm_out,
  input  wire les_pkg::les_pin_cfg_t            pin_cfg_in,
  input  wire logic                             pin_in,
  input  wire logic                             pin_out,
  input  wire logic                             pin_oe_out,
  input  wire logic                             pin_level_out,
  input  wire logic [2*ENGINES-1:0]             opm_out,
  input  wire logic [2*ENGINES-1:0]             engine_exec_mode_field_out,
  input  wire logic [les_pkg::PC_W*ENGINES-1:0] pc_out,
  input  wire logic                             load_active_out,
  input  wire logic [ENGINES-1:0]               exec_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  chk_dis_idle: assert property (
    (opm_out[1:0] == OPM_DISABLE)[*3] |-> !exec_out[0]) else $error("ran");
  chk_load_hold: assert property (
    load_active_out[*3] |-> exec_out == '0) else $error("load exec");
  chk_load_freeze: assert property (
    load_active_out[*2] |-> $stable(pwm_out)) else $error("pwm moved");
  chk_load_pc_clr: assert property (
    opm_out[1:0] == OPM_LOAD && $past(opm_out[1:0]) != OPM_LOAD
    |-> ##[0:2] pc_out[7:0] == 8'h00) else $error("pc kept");
  chk_no_run_load: assert property (
    $past(opm_out[1:0]) == OPM_RUN |-> opm_out[1:0] != OPM_LOAD)
    else $error("run to load");
  chk_step_clears: assert property (
    $rose(engine_exec_mode_field_out[1:0] == EXM_STEP)
    && opm_out[1:0] == OPM_RUN
    |-> ##[1:8] engine_exec_mode_field_out[1:0] == EXM_HOLD)
    else $error("step stuck");
  chk_pin_drive: assert property (
    ($stable(pin_cfg_in) && pin_cfg_in.func[1])[*3]
    |-> pin_oe_out && pin_out == pin_cfg_in.level) else $error("no drive");
  chk_pin_release: assert property (
    (!pin_cfg_in.func[1])[*3] |-> !pin_oe_out) else $error("drove");
  chk_pin_read: assert property (
    (!pin_cfg_in.func[1] && $stable(pin_in))[*5] |-> pin_level_out == pin_in)
    else $error("level");
  cov_load: cover property ($rose(load_active_out));
  cov_step: cover property ($rose(engine_exec_mode_field_out[1:0] == 2'h1));
  cov_halt: cover property ($rose(opm_out[1:0] == OPM_HALT));
endmodule
bind les_ctrl les_ctrl_props #(.ENGINES(ENGINES)) u_props (
  .clk_in(clk_in), .srst_in(srst_in), .pwm_out(pwm_out),
  .pin_cfg_in(pin_cfg_in), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe_out(pin_oe_out), .pin_level_out(pin_level_out),
  .opm_out(opm_out), .pc_out(pc_out), .load_active_out(load_active_out),
  .engine_exec_mode_field_out(engine_exec_mode_field_out),
  .exec_out(exec_out));

// ==== les_ctrl_tb.sv ====
`timescale 1ns/1ns
module les_ctrl_tb;
  import les_pkg::*;
  logic clk_in, srst_in, pin_in, chip_en, pin_o, pin_oe, pin_lvl, load_act;
  logic [2:0] opm_wr, exm_wr, pc_wr, exec;
  logic [5:0] opm_data, exm_data, opm, exm;
  logic [7:0] pc_data;
  logic [23:0] pwm_live, pwm, pc;
  logic [15:0] rd;
  les_mem_req_t mreq;
  les_pin_cfg_t pcfg;
  int fails, checked, cyc;
  les_host u_h (.clk_in(clk_in), .chip_en_out(chip_en),
    .opm_wr_out(opm_wr), .opm_data_out(opm_data), .exm_wr_out(exm_wr),
    .exm_data_out(exm_data), .pc_wr_out(pc_wr), .pc_data_out(pc_data),
    .mem_req_out(mreq));
  les_ctrl u_dut (.clk_in(clk_in), .srst_in(srst_in), .chip_en_in(chip_en),
    .opm_wr_in(opm_wr), .opm_data_in(opm_data), .exm_wr_in(exm_wr),
    .exm_data_in(exm_data), .pc_wr_in(pc_wr), .pc_data_in(pc_data),
    .mem_req_in(mreq), .mem_rd_data_out(rd), .pwm_live_in(pwm_live),
    .pwm_out(pwm), .pin_cfg_in(pcfg), .pin_in(pin_in), .pin_out(pin_o),
    .pin_oe_out(pin_oe), .pin_level_out(pin_lvl), .opm_out(opm),
    .engine_exec_mode_field_out(exm), .pc_out(pc),
    .load_active_out(load_act), .exec_out(exec), .fetch_data_out());
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic report_and_stop();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic t_pin();
    for (int f = 0; f < 4; f++) begin
      @(posedge clk_in);
      pcfg <= '{f[1:0], f[0]};
      pin_in <= f[0];
      wait_cyc(6);
      check(pin_oe, f[1]);
      if (f[1]) begin
        check(pin_o, f[0]);
        check(pin_lvl, 1);
      end else begin
        check(pin_lvl, f[0]);
      end
    end
    $display("t_pin done");
  endtask
  task automatic t_run();
    logic [7:0] p;
    u_h.wr(0, 0, OPM_RUN);
    u_h.wr(2, 0, 8'h10);
    check(pc[7:0], 8'h10);
    u_h.wr(1, 0, EXM_STEP);
    wait_cyc(6);
    check(pc[7:0], 8'h11);
    check(exm[1:0], EXM_HOLD);
    u_h.wr(1, 0, EXM_ONCE);
    wait_cyc(6);
    check(pc[7:0], 8'h11);
    check(exm[1:0], EXM_HOLD);
    u_h.wr(2, 0, 8'hFE);
    u_h.wr(1, 0, EXM_FREE);
    for (int i = 0; i < 20 && pc[7:0] !== 8'h00; i++) @(negedge clk_in);
    check(pc[7:0], 8'h00);
    u_h.wr(0, 0, OPM_HALT);
    wait_cyc(2);
    p = pc[7:0];
    wait_cyc(9);
    check(pc[7:0], p);
    u_h.wr(0, 0, OPM_RUN);
    wait_cyc(9);
    check(pc[7:0] !== p, 1);
    u_h.wr(1, 0, EXM_HOLD);
    wait_cyc(4);
    p = pc[7:0];
    wait_cyc(9);
    check(pc[7:0], p);
    $display("t_run done");
  endtask
  task automatic t_refuse();
    logic [7:0] p;
    u_h.wr(0, 0, OPM_LOAD);
    check(opm[1:0], OPM_RUN);
    check(load_act, 0);
    u_h.wr(0, 0, OPM_DISABLE);
    u_h.wr(1, 0, EXM_FREE);
    p = pc[7:0];
    wait_cyc(9);
    check(pc[7:0], p);
    $display("t_refuse done");
  endtask
  task automatic t_load();
    logic [7:0] p;
    u_h.wr(0, 1, OPM_RUN);
    u_h.wr(1, 1, EXM_FREE);
    u_h.wr(0, 0, OPM_LOAD);
    check(load_act, 1);
    check(pc[7:0], 8'h00);
    @(posedge clk_in);
    pwm_live <= 24'hABCDEF;
    // An instruction launched at the load edge may still finish first
    wait_cyc(2);
    p = pc[15:8];
    u_h.mem(1'b1, 4'hF, 4'h3, 16'hA55A);
    u_h.mem(1'b0, 4'hF, 4'h3, 16'h0000);
    check(rd, 16'hA55A);
    check(pwm, 24'h123456);
    check(pc[15:8], p);
    u_h.wr(0, 0, OPM_DISABLE);
    wait_cyc(9);
    check(pc[15:8] !== p, 1);
    $display("t_load done");
  endtask
  task automatic t_reset();
    @(posedge clk_in);
    srst_in <= 1'b1;
    wait_cyc(3);
    check(opm, 6'h00);
    check(exm, 6'h00);
    check(pc, 24'h000000);
    check({load_act, exec}, 4'h0);
    check(pwm, 24'h000000);
    @(posedge clk_in);
    srst_in <= 1'b0;
    wait_cyc(4);
    check(pwm, 24'hABCDEF);
    $display("t_reset done");
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    {srst_in, pin_in, pcfg, pwm_live} = {1'b1, 1'b0, 3'h0, 24'h123456};
    {fails, checked, cyc} = '0;
    repeat (16) @(posedge clk_in);
    srst_in <= 1'b0;
    u_h.en_up();
    t_pin();
    t_run();
    t_refuse();
    t_load();
    t_reset();
    report_and_stop();
  end
endmodule

// ==== les_engine.sv ====
`timescale 1ns/1ns
module les_engine
  import les_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 srst_in,
  // Control
  input  wire logic [1:0]           opm_in,
  input  wire logic                 gl_hold_in,
  input  wire logic [1:0]           exm_in,
  input  wire logic                 pc_wr_in,
  input  wire logic [les_pkg::PC_W-1:0] pc_data_in,
  // Status
  output logic [les_pkg::PC_W-1:0]  pc_out,
  output logic                      exm_clr_out,
  output logic                      exec_out
);
  typedef enum logic [1:0] {LES_IDLE, LES_FETCH, LES_EXEC} les_est_t;
  les_est_t st_r;
  logic [1:0] opm_q_r;
  logic       run_ok;
  logic       entering_load;

  // No new instruction launches unless running and not globally held
  assign run_ok = (opm_in == OPM_RUN) && !gl_hold_in;
  assign entering_load = (opm_in == OPM_LOAD) && (opm_q_r != OPM_LOAD);
  assign exec_out = (st_r == LES_EXEC);

  always_ff @(posedge clk_in) begin
    if (srst_in) opm_q_r <= OPM_DISABLE;
    else         opm_q_r <= opm_in;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in || opm_in != OPM_RUN) begin
      st_r <= LES_IDLE;
    end else begin
      unique case (st_r)
        // The auto-clear lands a cycle late; never relaunch on a stale step
        LES_IDLE:  if (run_ok && exm_in != EXM_HOLD && !exm_clr_out) begin
          st_r <= LES_FETCH;
        end
        LES_FETCH: st_r <= LES_EXEC;
        // Hold lets the current instruction finish
        LES_EXEC:  st_r <= LES_IDLE;
        default:   st_r <= LES_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    exm_clr_out <= 1'b0;
    if (srst_in) begin
      pc_out <= PC_RST;
    end else if (entering_load) begin
      pc_out <= PC_RST;
    end else if (pc_wr_in) begin
      pc_out <= pc_data_in;
    end else if (st_r == LES_EXEC && opm_in == OPM_RUN) begin
      if (exm_in != EXM_ONCE) begin
        pc_out <= (pc_out == PC_LIMIT) ? PC_RST
                : pc_out + 8'h01;
      end
      if (exm_in == EXM_STEP || exm_in == EXM_ONCE) begin
        exm_clr_out <= 1'b1;
      end
    end
  end
endmodule

// ==== les_host.sv ====
`timescale 1ns/1ns
module les_host
  import les_pkg::*;
(
  // Clock
  input  wire logic     clk_in,
  // Host requests
  output logic          chip_en_out,
  output logic [2:0]    opm_wr_out,
  output logic [5:0]    opm_data_out,
  output logic [2:0]    exm_wr_out,
  output logic [5:0]    exm_data_out,
  output logic [2:0]    pc_wr_out,
  output logic [7:0]    pc_data_out,
  output les_mem_req_t  mem_req_out
);
  initial begin
    chip_en_out = 1'b0;
    {opm_wr_out, opm_data_out, exm_wr_out, exm_data_out} = '0;
    {pc_wr_out, pc_data_out, mem_req_out} = '0;
  end
  // Enable first, then wait out the two-flop sync before any access
  task automatic en_up();
    @(posedge clk_in);
    chip_en_out <= 1'b1;
    repeat (3) @(posedge clk_in);
  endtask
  // k: 0 operating mode, 1 execution mode, 2 program counter
  task automatic wr(input int k, input int e, input logic [7:0] v);
    @(posedge clk_in);
    if (k == 0) begin
      opm_wr_out[e] <= 1'b1;
      opm_data_out[2*e+:2] <= v[1:0];
    end else if (k == 1) begin
      exm_wr_out[e] <= 1'b1;
      exm_data_out[2*e+:2] <= v[1:0];
    end else begin
      pc_wr_out[e] <= 1'b1;
      pc_data_out <= v;
    end
    @(posedge clk_in);
    {opm_wr_out, exm_wr_out, pc_wr_out} <= '0;
    // Released data is scrambled so stale values are never relied on
    opm_data_out <= ~opm_data_out;
    exm_data_out <= ~exm_data_out;
    pc_data_out <= ~pc_data_out;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  task automatic mem(input logic w, input logic [3:0] p, input logic [3:0] a,
                     input logic [15:0] d);
    @(posedge clk_in);
    mem_req_out <= '{w, p, a, d};
    @(posedge clk_in);
    mem_req_out.wr <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
endmodule

// ==== les_pkg.sv ====
package les_pkg;

  localparam int NUM_ENG    = 3;
  localparam int PC_W       = 8;
  localparam int PAGE_W     = 4;
  localparam int NUM_PAGES  = 16;
  localparam int WORD_W     = 16;
  localparam int PAGE_WORDS = 16;
  localparam int MEM_AW     = 8;

  // Master operating mode, per engine, two bits
  localparam logic [1:0] OPM_DISABLE = 2'h0;
  localparam logic [1:0] OPM_LOAD    = 2'h1;
  localparam logic [1:0] OPM_RUN     = 2'h2;
  localparam logic [1:0] OPM_HALT    = 2'h3;

  // Engine execution mode field
  localparam logic [1:0] EXM_HOLD    = 2'h0;
  localparam logic [1:0] EXM_STEP    = 2'h1;
  localparam logic [1:0] EXM_FREE    = 2'h2;
  localparam logic [1:0] EXM_ONCE    = 2'h3;

  // Pin function field
  localparam logic [1:0] PINF_IN_A   = 2'h0;
  localparam logic [1:0] PINF_IN_B   = 2'h1;
  localparam logic [1:0] PINF_OUT_A  = 2'h2;
  localparam logic [1:0] PINF_OUT_B  = 2'h3;

  localparam logic [PC_W-1:0] PC_RST    = 8'h00;
  localparam logic [PC_W-1:0] PC_LIMIT  = 8'hFF;

  typedef struct packed {
    logic              wr;
    logic [PAGE_W-1:0] page;
    logic [3:0]        word;
    logic [WORD_W-1:0] data;
  } les_mem_req_t;

  typedef struct packed {
    logic [1:0] func;
    logic       level;
  } les_pin_cfg_t;

endpackage

// ==== les_prog_mem.sv ====
`timescale 1ns/1ns
module les_prog_mem
  import les_pkg::*;
#(
  parameter int PAGES = NUM_PAGES,
  parameter int WORDS = PAGE_WORDS
) (
  // Clock
  input  wire logic                 clk_in,
  // Host port
  input  wire les_pkg::les_mem_req_t req_in,
  input  wire logic                 wr_allow_in,
  output logic [les_pkg::WORD_W-1:0] rd_data_out,
  // Engine fetch port
  input  wire logic [les_pkg::MEM_AW-1:0] fetch_addr_in,
  output logic [les_pkg::WORD_W-1:0] fetch_data_out
);
  logic [WORD_W-1:0] mem [PAGES*WORDS];

  always_ff @(posedge clk_in) begin
    if (req_in.wr && wr_allow_in) begin
      mem[{req_in.page, req_in.word}] <= req_in.data;
    end
  end

  always_ff @(posedge clk_in) begin
    rd_data_out    <= mem[{req_in.page, req_in.word}];
    fetch_data_out <= mem[fetch_addr_in];
  end
endmodule
